// File: bbox_map.svh
// Register offsets, EEPROM layout, reset values and timing counts.
`ifndef BBOX_MAP_SVH
`define BBOX_MAP_SVH

`define OFS_LATCH_LOW    8'h00
`define OFS_LATCH_HIGH   8'h04
`define OFS_LIVE_STATUS  8'h08
`define OFS_SNAP_STATUS  8'h0C
`define OFS_REC_CTRL     8'h10
`define OFS_REC_STATUS   8'h14

`define CTRL_REC_EN_BIT  0
`define CTRL_RESCAN_BIT  1
`define CTRL_RESET       1'b0

`define USER_BASE        16'hF900
`define USER_LAST        16'hF9FF
`define REC_BASE         16'hF980
`define REC_LAST_SLOT    16'hF9F8
`define REC_SLOTS        5'h10
`define REC_LAST_IDX     4'hF
`define REC_LAST_BYTE    3'h7
`define REC_USED_BIT     7

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define CLK_PERIOD_NS    20
`define BYTE_PROG_NS     250000

`endif

// File: bbox_pkg.sv
// Types shared by the fault latch and black box recorder.
package bbox_pkg;

  typedef enum logic [1:0] {
    CAUSE_SEQUENCE,
    CAUSE_TIMEOUT,
    CAUSE_MONITOR
  } exit_cause_t;

  typedef struct packed {
    logic        change;
    logic [5:0]  next_state;
    exit_cause_t cause;
    logic        latch_en;
    logic        record_state;
  } seq_event_t;

  typedef struct packed {
    logic [7:0] lim;
    logic [3:0] gpi;
    logic [7:0] ov;
    logic [7:0] uv;
  } status_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ee_cmd_t;

  typedef enum logic [2:0] {
    ST_SCAN,
    ST_IDLE,
    ST_PROG,
    ST_PACE,
    ST_FULL
  } rec_state_t;

endpackage

// File: byte_pace_timer.sv
// Down counter that spaces successive EEPROM byte programs.
`timescale 1ns/100ps
`default_nettype none

module byte_pace_timer #(
  parameter int unsigned CYCLES = 12500
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic start,
  output logic      done
);

  localparam int unsigned W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge CLK) begin
    if (RST)
      cnt_ff <= '0;
    else if (start)
      cnt_ff <= W'(CYCLES);
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - 1'b1;
  end

  assign done = (cnt_ff == '0) && !start;

endmodule // byte_pace_timer

`default_nettype wire

// File: eeprom_model.sv
// Behavioural EEPROM model of the user region that sits behind the recorder.
`timescale 1ns/100ps
`default_nettype none
`include "bbox_map.svh"

module eeprom_model (
  input  wire logic              clk,
  input  wire logic              slow,
  input  wire bbox_pkg::ee_cmd_t cmd,
  output logic                   ack,
  output logic [7:0]             rdata
);
  import bbox_pkg::*;
  logic [7:0]  mem [0:255];
  logic [3:0]  wait_ff;
  logic [7:0]  last_ff;
  int unsigned n_prog;
  int unsigned n_bad;

  // The host clears the whole region to the unused pattern.
  task automatic erase();
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  endtask

  initial begin
    ack = 1'b0;
    wait_ff = 4'h0;
    last_ff = 8'h00;
    n_prog = 0;
    n_bad = 0;
    erase();
  end

  // Outside an acknowledge the data lines are not held, so they toggle.
  assign rdata = ack ? mem[cmd.addr[7:0]] : ~last_ff;

  // Only byte reads and byte programs exist; there is no erase command.
  always @(posedge clk) begin
    if (ack) begin
      ack <= 1'b0;
      last_ff <= rdata;
    end else if (cmd.req) begin
      if (wait_ff == (slow ? 4'h5 : 4'h0)) begin
        ack <= 1'b1;
        wait_ff <= 4'h0;
        if (cmd.addr < `REC_BASE || cmd.addr > `USER_LAST) begin
          n_bad <= n_bad + 1;
        end
        if (cmd.write) begin
          mem[cmd.addr[7:0]] <= cmd.wdata;
          n_prog <= n_prog + 1;
        end
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule // eeprom_model

`default_nettype wire

// File: fault_black_box.sv
// Fault latch, live and snapshot status, and EEPROM black box recorder.
//
// Operation
// - One latch bit per input, set by its fault, readable by host.
// - Each sequencer state's config enables or disables fault latching.
// - Status registers report per-input UV, OV and limit faults.
// - Live status follows inputs without latching.
// - Snapshot status captured at each state change, held until next.
// - 0xF980..0xF9FF is user storage unless recording is enabled.
// - Records use 0xF980..0xF9FF, sixteen at most.
// - Entering a record-writing state launches one record write.
// - Record holds status captured as the previous state was left.
// - Record: used flag 0, previous state, exit cause, status, checksum.
// - Record is eight bytes programmed one by one, about 2 ms.
// - A started record write finishes before any other begins.
// - After power-on, scan slots for first used flag reading 1.
// - Slots start at 0xF980 in steps of eight, last at 0xF9F8.
// - Recorder only programs bytes, never erases.
// - With all slots used, stop writing and keep earliest records.
// - Host erases then resets recorder; recorder rescans for free slot.
// - Exit cause distinguishes sequence, monitor and timeout routes.
// - Previous-state field wide enough for 63 states.
`timescale 1ns/100ps
`default_nettype none
`include "bbox_map.svh"

module fault_black_box #(
  parameter int unsigned BYTE_PROG_CYCLES =
    (`BYTE_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic [7:0]          UV_PINS,
  input  wire logic [7:0]          OV_PINS,
  input  wire logic [3:0]          GP_INPUT_PINS,
  input  wire logic [7:0]          CONVERSION_LIMIT_FLAGS,
  input  wire bbox_pkg::seq_event_t SEQ,
  output bbox_pkg::ee_cmd_t        EE_CMD,
  input  wire logic                EE_ACK,
  input  wire logic [7:0]          EE_RDATA,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [7:0]          AWADDR,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic [1:0]               BRESP,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [7:0]          ARADDR,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP
);
  import bbox_pkg::*;

  // Comparator pins are asynchronous; a bit moves only when the last two
  // stages agree, which also rejects a single-stage glitch.
  logic [19:0]     pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff;
  status_t         live;
  status_t         snap_ff;
  logic [7:0]      fault_lo, lat_lo_ff, lat_hi_ff, nxt_lat_lo, nxt_lat_hi;
  logic            latch_en_ff;
  logic [5:0]      cur_state_ff, prev_state_ff;
  exit_cause_t     cause_ff;
  rec_state_t      st_ff, nxt_st;
  logic [3:0]      slot_ff, nxt_slot;
  logic [2:0]      bidx_ff, nxt_bidx;
  logic [7:0][7:0] rbuf_ff, nrec;
  logic [7:0]      sum;
  logic            rec_en_ff, rescan_ff, pace_start, pace_done, rec_go;
  logic            aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0]      awaddr_ff;
  logic [31:0]     wdata_ff, rdata_ff, nxt_rdata;
  logic [3:0]      wstrb_ff;
  logic [1:0]      bresp_ff, rresp_ff, nxt_rresp;
  logic [4:0]      used_count;

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_ff    <= '0;
    end else begin
      pin_s1_ff <= {GP_INPUT_PINS, OV_PINS, UV_PINS};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff    <= (pin_s2_ff & pin_s3_ff) |
                   (pin_ff & (pin_s2_ff | pin_s3_ff));
    end
  end

  assign live = {CONVERSION_LIMIT_FLAGS, pin_ff};
  assign fault_lo = live.uv | live.ov;

  // Write-one-to-clear from the host; a fault in the same cycle wins.
  logic       wr_do, sel_lo, sel_hi, sel_ctrl;
  logic [7:0] clr_lo, clr_hi;
  assign wr_do    = aw_ff && w_ff && !bvalid_ff;
  assign sel_lo   = wr_do && awaddr_ff == `OFS_LATCH_LOW && wstrb_ff[0];
  assign sel_hi   = wr_do && awaddr_ff == `OFS_LATCH_HIGH && wstrb_ff[0];
  assign sel_ctrl = wr_do && awaddr_ff == `OFS_REC_CTRL && wstrb_ff[0];
  assign clr_lo   = sel_lo ? wdata_ff[7:0] : 8'h00;
  assign clr_hi   = sel_hi ? wdata_ff[7:0] : 8'h00;
  assign nxt_lat_lo = (lat_lo_ff & ~clr_lo) |
                      (latch_en_ff ? fault_lo : 8'h00);
  assign nxt_lat_hi = (lat_hi_ff & ~clr_hi) |
                      (latch_en_ff ? live.lim : 8'h00);

  always_ff @(posedge CLK) begin
    if (RST) begin
      lat_lo_ff   <= 8'h00;
      lat_hi_ff   <= 8'h00;
      latch_en_ff <= 1'b0;
    end else begin
      lat_lo_ff <= nxt_lat_lo;
      lat_hi_ff <= nxt_lat_hi;
      if (SEQ.change)
        latch_en_ff <= SEQ.latch_en;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      snap_ff       <= '0;
      cur_state_ff  <= 6'h00;
      prev_state_ff <= 6'h00;
      cause_ff      <= CAUSE_SEQUENCE;
    end else if (SEQ.change) begin
      snap_ff       <= live;
      prev_state_ff <= cur_state_ff;
      cur_state_ff  <= SEQ.next_state;
      cause_ff      <= SEQ.cause;
    end
  end

  // The record is built from the same values the snapshot takes at the
  // state change, so it reflects the moment the old state was left.
  always_comb begin
    nrec[0] = {1'b0, 1'b0, cur_state_ff};
    nrec[1] = {SEQ.cause, 2'b00, live.gpi};
    nrec[2] = live.uv;
    nrec[3] = live.ov;
    nrec[4] = live.lim;
    nrec[5] = nxt_lat_lo;
    nrec[6] = nxt_lat_hi;
    sum = 8'h00;
    for (int i = 0; i < 7; i++)
      sum = sum + nrec[i];
    nrec[7] = 8'h00 - sum;
  end

  assign rec_go = SEQ.change && SEQ.record_state && rec_en_ff;

  always_comb begin
    nxt_st     = st_ff;
    nxt_slot   = slot_ff;
    nxt_bidx   = bidx_ff;
    pace_start = 1'b0;
    case (st_ff)
      ST_SCAN: begin
        if (EE_ACK) begin
          if (EE_RDATA[`REC_USED_BIT])
            nxt_st = ST_IDLE;
          else if (slot_ff == `REC_LAST_IDX)
            nxt_st = ST_FULL;
          else
            nxt_slot = slot_ff + 4'h1;
        end
      end
      ST_IDLE: begin
        if (rescan_ff) begin
          nxt_st   = ST_SCAN;
          nxt_slot = 4'h0;
        end else if (rec_go) begin
          nxt_st   = ST_PROG;
          nxt_bidx = 3'h0;
        end
      end
      ST_PROG: begin
        if (EE_ACK) begin
          pace_start = 1'b1;
          nxt_st     = ST_PACE;
        end
      end
      ST_PACE: begin
        if (pace_done) begin
          if (bidx_ff != `REC_LAST_BYTE) begin
            nxt_bidx = bidx_ff + 3'h1;
            nxt_st   = ST_PROG;
          end else if (slot_ff == `REC_LAST_IDX) begin
            nxt_st = ST_FULL;
          end else begin
            nxt_slot = slot_ff + 4'h1;
            nxt_st   = ST_IDLE;
          end
        end
      end
      ST_FULL: begin
        if (rescan_ff) begin
          nxt_st   = ST_SCAN;
          nxt_slot = 4'h0;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // A rescan requested mid-record waits until the record is finished.
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_ff     <= ST_SCAN;
      slot_ff   <= 4'h0;
      bidx_ff   <= 3'h0;
      rbuf_ff   <= '0;
      rec_en_ff <= `CTRL_RESET;
      rescan_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      slot_ff <= nxt_slot;
      bidx_ff <= nxt_bidx;
      if (st_ff == ST_IDLE && rec_go && !rescan_ff)
        rbuf_ff <= nrec;
      if (sel_ctrl)
        rec_en_ff <= wdata_ff[`CTRL_REC_EN_BIT];
      if (sel_ctrl && wdata_ff[`CTRL_RESCAN_BIT])
        rescan_ff <= 1'b1;
      else if (nxt_st == ST_SCAN && st_ff != ST_SCAN)
        rescan_ff <= 1'b0;
    end
  end

  byte_pace_timer #(
    .CYCLES (BYTE_PROG_CYCLES)
  ) u_pace (
    .CLK   (CLK),
    .RST   (RST),
    .start (pace_start),
    .done  (pace_done)
  );

  // Only scan reads and byte programs exist on this port; the area is never erased.
  assign EE_CMD.req   = (st_ff == ST_SCAN) || (st_ff == ST_PROG);
  assign EE_CMD.write = (st_ff == ST_PROG);
  assign EE_CMD.addr  = `REC_BASE +
    {9'h000, slot_ff, (st_ff == ST_PROG) ? bidx_ff : 3'h0};
  assign EE_CMD.wdata = rbuf_ff[bidx_ff];

  assign used_count = (st_ff == ST_FULL) ? `REC_SLOTS : {1'b0, slot_ff};

  // AXI4-Lite slave: address and data are taken in either order, one
  // write response and one read response outstanding at most.
  assign AWREADY = !aw_ff && !bvalid_ff;
  assign WREADY  = !w_ff && !bvalid_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = !rvalid_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;

  logic wr_known;
  assign wr_known = awaddr_ff == `OFS_LATCH_LOW ||
                    awaddr_ff == `OFS_LATCH_HIGH ||
                    awaddr_ff == `OFS_REC_CTRL;

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bresp_ff  <= `RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_ff     <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      if (wr_do) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_rresp = `RESP_OKAY;
    if (ARADDR == `OFS_LATCH_LOW)
      nxt_rdata = {24'h000000, lat_lo_ff};
    else if (ARADDR == `OFS_LATCH_HIGH)
      nxt_rdata = {24'h000000, lat_hi_ff};
    else if (ARADDR == `OFS_LIVE_STATUS)
      nxt_rdata = {4'h0, live};
    else if (ARADDR == `OFS_SNAP_STATUS)
      nxt_rdata = {4'h0, snap_ff};
    else if (ARADDR == `OFS_REC_CTRL)
      nxt_rdata = {30'h0000_0000, rescan_ff, rec_en_ff};
    else if (ARADDR == `OFS_REC_STATUS)
      nxt_rdata = {24'h000000, st_ff == ST_SCAN,
                   st_ff == ST_PROG || st_ff == ST_PACE,
                   st_ff == ST_FULL, used_count};
    else begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `RESP_SLVERR;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_prog_in_region: assert property (
    EE_CMD.write |-> EE_CMD.addr >= `REC_BASE &&
                     EE_CMD.addr <= `USER_LAST)
    else $error("Record byte programmed outside the record area.");

  a_slot_aligned: assert property (
    (st_ff == ST_PROG && bidx_ff == 3'h0) |->
      EE_CMD.addr[2:0] == 3'h0 && EE_CMD.addr <= `REC_LAST_SLOT)
    else $error("Record does not start on a slot boundary.");

  a_record_sum: assert property (
    st_ff == ST_PROG |-> (rbuf_ff[0] + rbuf_ff[1] + rbuf_ff[2] +
      rbuf_ff[3] + rbuf_ff[4] + rbuf_ff[5] + rbuf_ff[6] +
      rbuf_ff[7]) == 8'h00 && !rbuf_ff[0][`REC_USED_BIT])
    else $error("Record checksum or used flag is wrong.");

  // A record that ends in the same cycle still steps to the next slot.
  a_no_restart: assert property (
    (st_ff inside {ST_PROG, ST_PACE} && rec_go) |=>
      $stable(rbuf_ff) &&
      ($stable(slot_ff) || $past(st_ff == ST_PACE && pace_done)))
    else $error("Record write restarted before completion.");

  a_full_quiet: assert property (
    st_ff == ST_FULL |-> !EE_CMD.req)
    else $error("Recorder accessed EEPROM while full.");

  a_latch_keep: assert property (
    (!latch_en_ff && !sel_lo) |=> lat_lo_ff == $past(lat_lo_ff))
    else $error("Fault latch changed while latching disabled.");

  a_latch_sets: assert property (
    latch_en_ff |=> (lat_lo_ff & $past(fault_lo)) == $past(fault_lo))
    else $error("Fault did not set its latch bit.");

  a_snap_take: assert property (
    SEQ.change |=> snap_ff == $past(live))
    else $error("Snapshot status not taken at the state change.");

  a_snap_hold: assert property (
    !SEQ.change |=> $stable(snap_ff))
    else $error("Snapshot status changed without a state change.");

  a_scan_first: assert property (
    (st_ff == ST_SCAN && EE_ACK && EE_RDATA[`REC_USED_BIT]) |=>
      st_ff == ST_IDLE && slot_ff == $past(slot_ff))
    else $error("Scan did not stop at the first free slot.");

  a_go_writes: assert property (
    (st_ff == ST_IDLE && rec_go && !rescan_ff) |=>
      st_ff == ST_PROG && bidx_ff == 3'h0)
    else $error("Record state entry did not start a write.");

  c_scan_hit: cover property (st_ff == ST_SCAN ##1 st_ff == ST_IDLE);
  c_record_done: cover property (
    st_ff == ST_PACE && bidx_ff == `REC_LAST_BYTE ##1 st_ff == ST_IDLE);
  c_full: cover property (st_ff == ST_PACE ##1 st_ff == ST_FULL);
  c_rescan: cover property (st_ff == ST_FULL ##1 st_ff == ST_SCAN);

endmodule // fault_black_box

`default_nettype wire

// File: tb.sv
// Self-checking testbench for the fault latch and black box recorder.
`timescale 1ns/100ps
`default_nettype none
`include "bbox_map.svh"

module tb;
  import bbox_pkg::*;
  logic        CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, EE_ACK, slow;
  logic [7:0]  UV_PINS, OV_PINS, CONVERSION_LIMIT_FLAGS, AWADDR, ARADDR;
  logic [7:0]  EE_RDATA;
  logic [3:0]  GP_INPUT_PINS, WSTRB;
  logic [31:0] WDATA, RDATA, d;
  logic [1:0]  BRESP, RRESP, r;
  seq_event_t  SEQ;
  ee_cmd_t     EE_CMD;
  int          n_errors, tests_run;

  fault_black_box #(.BYTE_PROG_CYCLES(4)) fault_black_box_i (
    .CLK(CLK), .RST(RST), .UV_PINS(UV_PINS), .OV_PINS(OV_PINS),
    .GP_INPUT_PINS(GP_INPUT_PINS),
    .CONVERSION_LIMIT_FLAGS(CONVERSION_LIMIT_FLAGS), .SEQ(SEQ),
    .EE_CMD(EE_CMD), .EE_ACK(EE_ACK), .EE_RDATA(EE_RDATA),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

  eeprom_model eeprom_model_i (
    .clk(CLK), .slow(slow), .cmd(EE_CMD), .ack(EE_ACK), .rdata(EE_RDATA));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    chk(32'h0, 32'h1);
    final_report();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    AWVALID <= 1'b1; AWADDR <= a; WVALID <= 1'b1; WDATA <= v; BREADY <= 1'b1;
    do begin
      @(posedge CLK); n++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!(BVALID && BREADY) && n < 100);
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge CLK);
    if (n >= 100) tmo();
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    ARVALID <= 1'b1; ARADDR <= a; RREADY <= 1'b1;
    do begin
      @(posedge CLK); n++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!(RVALID && RREADY) && n < 100);
    d = RDATA; r = RRESP; RREADY <= 1'b0;
    @(posedge CLK);
    if (n >= 100) tmo();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    chk(d, exp);
  endtask

  // Polls the recorder status word; a stuck recorder ends the run.
  task automatic wait_st(input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    do begin
      axi_read(`OFS_REC_STATUS);
      n++;
    end while ((d & mask) !== val && n < 500);
    if (n >= 500) tmo();
  endtask

  task automatic seq_go(input logic [5:0] st, input exit_cause_t c,
                        input logic le, input logic rs);
    SEQ <= '{1'b1, st, c, le, rs};
    @(posedge CLK);
    SEQ.change <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rec_chk(input int slot, input logic [5:0] prev,
                         input exit_cause_t c, input logic [3:0] g,
                         input logic [7:0] u, input logic [7:0] o,
                         input logic [7:0] l, input logic [7:0] ll,
                         input logic [7:0] lh);
    logic [7:0] e [8];
    logic [7:0] s;
    e = '{{2'b00, prev}, {c, 2'b00, g}, u, o, l, ll, lh, 8'h00};
    s = 8'h00;
    for (int k = 0; k < 7; k++) s = s + e[k];
    e[7] = 8'h00 - s;
    for (int k = 0; k < 8; k++)
      chk({24'h0, eeprom_model_i.mem[8'(8'h80 + slot * 8 + k)]},
          {24'h0, e[k]});
  endtask

  initial begin
    n_errors = 0; tests_run = 0; slow = 1'b0; RST = 1'b1;
    AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0; ARVALID = 1'b0;
    RREADY = 1'b0; AWADDR = 8'h00; ARADDR = 8'h00; WDATA = 32'h0;
    WSTRB = 4'hF; UV_PINS = 8'h00; OV_PINS = 8'h00; GP_INPUT_PINS = 4'h0;
    CONVERSION_LIMIT_FLAGS = 8'h00; SEQ = '0;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    wait_st(32'h80, 32'h0);
    chk(d, 32'h0);
    axi_write(8'h18, 32'h1);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    rd_chk(`OFS_REC_CTRL, 32'h0);
    rd_chk(8'h18, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    seq_go(6'd3, CAUSE_SEQUENCE, 1'b1, 1'b1);
    UV_PINS <= 8'h02; OV_PINS <= 8'h04; GP_INPUT_PINS <= 4'hA;
    CONVERSION_LIMIT_FLAGS <= 8'h08;
    repeat (8) @(posedge CLK);
    chk(eeprom_model_i.n_prog, 0);
    rd_chk(`OFS_LIVE_STATUS, 32'h008A0402);
    rd_chk(`OFS_LATCH_LOW, 32'h06);
    rd_chk(`OFS_LATCH_HIGH, 32'h08);
    axi_write(`OFS_REC_CTRL, 32'h1);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    seq_go(6'd9, CAUSE_MONITOR, 1'b0, 1'b1);
    seq_go(6'd10, CAUSE_SEQUENCE, 1'b0, 1'b1);
    UV_PINS <= 8'h00; OV_PINS <= 8'h00; GP_INPUT_PINS <= 4'h5;
    CONVERSION_LIMIT_FLAGS <= 8'h00;
    repeat (8) @(posedge CLK);
    rd_chk(`OFS_SNAP_STATUS, 32'h008A0402);
    rd_chk(`OFS_LIVE_STATUS, 32'h00050000);
    rd_chk(`OFS_LATCH_LOW, 32'h06);
    wait_st(32'h40, 32'h0);
    chk(eeprom_model_i.n_prog, 8);
    rec_chk(0, 6'h03, CAUSE_MONITOR, 4'hA, 8'h02,
            8'h04, 8'h08, 8'h06, 8'h08);
    rd_chk(`OFS_REC_STATUS, 32'h01);
    axi_write(`OFS_LATCH_LOW, 32'hFF);
    axi_write(`OFS_LATCH_HIGH, 32'hFF);
    rd_chk(`OFS_LATCH_LOW, 32'h0);
    rd_chk(`OFS_LATCH_HIGH, 32'h0);
    UV_PINS <= 8'h10;
    repeat (8) @(posedge CLK);
    rd_chk(`OFS_LATCH_LOW, 32'h0);
    UV_PINS <= 8'h00;
    for (int i = 1; i < 15; i++)
      eeprom_model_i.mem[8'(8'h80 + i * 8)] = 8'h00;
    slow <= 1'b1;
    axi_write(`OFS_REC_CTRL, 32'h3);
    wait_st(32'h80, 32'h0);
    chk(d, 32'h0F);
    seq_go(6'd20, CAUSE_TIMEOUT, 1'b0, 1'b1);
    wait_st(32'h40, 32'h0);
    rec_chk(15, 6'h0A, CAUSE_TIMEOUT, 4'h5, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00);
    chk(d, 32'h30);
    seq_go(6'd21, CAUSE_SEQUENCE, 1'b0, 1'b1);
    repeat (40) @(posedge CLK);
    chk(eeprom_model_i.n_prog, 16);
    eeprom_model_i.erase();
    axi_write(`OFS_REC_CTRL, 32'h3);
    wait_st(32'h80, 32'h0);
    chk(d, 32'h0);
    chk(eeprom_model_i.n_bad, 0);
    final_report();
  end
endmodule // tb

`default_nettype wire
